// ===== inc/sucr_defines.vh
`ifndef SUCR_DEFINES_VH
`define SUCR_DEFINES_VH

// ----------------------------------------
// Instance placement
// ----------------------------------------
`define SUCR_BASE_ADDR 32'h400D_0000
`define SUCR_INST_STRIDE 32'h0000_1000

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SUCR_OFS_FUNC 8'h00
`define SUCR_OFS_IRQEN 8'h04
`define SUCR_OFS_BAUD 8'h08
`define SUCR_OFS_DATIN 8'h10
`define SUCR_OFS_CTLIN 8'h20
`define SUCR_OFS_CLKIN 8'h28
`define SUCR_OFS_LINE 8'h2C
`define SUCR_OFS_TXW 8'h30
`define SUCR_OFS_RXW 8'h34
`define SUCR_OFS_BUFC 8'h38
`define SUCR_OFS_BUFS 8'h3C
`define SUCR_OFS_DMAC 8'h40
`define SUCR_OFS_WKC 8'h54
`define SUCR_OFS_WKS 8'h58
`define SUCR_OFS_PROT 8'h5C
`define SUCR_OFS_PIEN 8'h60
`define SUCR_OFS_PSTS 8'h64
`define SUCR_OFS_EVT 8'h68

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SUCR_RST_BAUD 32'h0000_3C00
`define SUCR_RST_BUFS 32'h0000_0101

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define SUCR_MODE_OFF 3'h0
`define SUCR_MODE_SPI 3'h1
`define SUCR_MODE_UART 3'h2
`define SUCR_MODE_TWI 3'h4
`define SUCR_DIV_HI 25
`define SUCR_DIV_LO 16
`define SUCR_DEN_HI 14
`define SUCR_DEN_LO 10
`define SUCR_PRE_HI 9
`define SUCR_PRE_LO 8
`define SUCR_MSRC_BIT 5
`define SUCR_MEN_BIT 4
`define SUCR_SCS_HI 3
`define SUCR_SCS_LO 2
`define SUCR_PCS_BIT 1
`define SUCR_RCS_BIT 0
`define SUCR_EDGE_HI 4
`define SUCR_EDGE_LO 3
`define SUCR_INV_BIT 2
`define SUCR_SYNC_BIT 0
`define SUCR_ABR_BIT 6
`define SUCR_ABRAUTO_CNT 3'h4

// ----------------------------------------
// Bus timing
// ----------------------------------------
`define SUCR_WAIT_CYCLES 1

`endif

// ===== core/sucr_divider.v
`default_nettype none
`include "sucr_defines.vh"

// Enable-pulse divider: pulses once per (ratio+1) input enables
module sucr_divider #(
   parameter W = 10
) (
   // System
   input wire clock,
   input wire rst_n,
   // Control
   input wire clear,
   input wire en_in,
   input wire [W-1:0] ratio,
   // Output
   output reg en_out
);

   reg [W-1:0] cnt_r;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= {W{1'b0}};
         en_out <= 1'b0;
      end else if (clear) begin
         cnt_r <= {W{1'b0}};
         en_out <= 1'b0;
      end else begin
         en_out <= 1'b0;
         if (en_in) begin
            if (cnt_r >= ratio) begin
               cnt_r <= {W{1'b0}};
               en_out <= 1'b1;
            end else begin
               cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // sucr_divider

`default_nettype wire

// ===== core/sucr_config_regs.v
// Contract
// - Mode codes: off, sync, async, two-wire
// - Reserved mode code disables the unit
// - Writing zero mode resets to idle
// - Four per-event interrupt enables gate events
// - Divider clock is protocol clock over divider+1
// - Auto baud rewrites divider on 0x55
// - Prescaled sample clock over denominator+1
// - Sample clock over prescale+1
// - Ten-bit measure counter runs when enabled
// - Measure counter clock: protocol or divider
// - Sample clock source four-way select
// - Protocol clock is reference or half
// - Reference clock is peripheral clock only
// - Edge field selects data event edges
// - Inversion bit inverts raw input
// - Sync bit picks raw or synchronised input
// - Two instances at base plus stride
// - Four transfer events from the shift unit
//
// The Avalon-MM interface to the registers was left to the implementer.
`default_nettype none
`include "sucr_defines.vh"

module sucr_config_regs #(
   parameter INSTANCE = 0,
   parameter DIV_W = 10
) (
   // System
   input wire clock,
   input wire rst_n,
   // Avalon-MM slave
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg [1:0] avs_response,
   // Line inputs and serial clock enable
   input wire data_in,
   input wire ctrl_in,
   input wire sclk_en,
   // Shift unit events
   input wire tx_begin_evt,
   input wire tx_done_evt,
   input wire rx_begin_evt,
   input wire rx_done_evt,
   input wire [15:0] rx_word,
   // Conditioned outputs
   output reg protocol_active,
   output reg [2:0] protocol_select_o,
   output reg unit_reset,
   output reg data_shift_in,
   output reg ctrl_shift_in,
   output reg data_edge_evt,
   output reg div_clk_en,
   output reg sample_cnt_en,
   output reg [9:0] measure_count,
   output reg irq
);

   localparam [31:0] MY_BASE = `SUCR_BASE_ADDR + INSTANCE * `SUCR_INST_STRIDE;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [2:0] protocol_select_r;
   reg [4:1] irq_en_r;
   reg [31:0] baud_r;
   reg [4:0] datin_r;
   reg [2:0] ctlin_r;
   reg clkin_r;
   reg [11:0] line_r;
   reg [15:0] txw_r;
   reg [31:0] prot_r;
   reg [3:0] dmac_r;
   reg wkc_r;
   reg [4:1] flags_r;
   reg [15:0] rxw_r;
   reg rd_pend_r;
   reg [31:0] rd_nxt;
   reg [1:0] ref_half_r;
   reg [9:0] meas_r;
   reg [1:0] d_sync_r;
   reg [1:0] c_sync_r;
   reg [2:0] abr_edges_r;
   reg [9:0] abr_cnt_r;
   reg abr_arm_r;
   reg d_prev_r;

   wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire wr_go = avs_write & avs_waitrequest;
   wire rd_go = avs_read & avs_waitrequest;

   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [31:0] m;
      begin
         merge = (old_v & ~m) | (new_v & m);
      end
   endfunction

   function mode_valid;
      input [2:0] m;
      begin
         mode_valid = (m == `SUCR_MODE_SPI) || (m == `SUCR_MODE_UART) ||
            (m == `SUCR_MODE_TWI);
      end
   endfunction

   function is_mapped;
      input [7:0] a;
      begin
         case (a)
            `SUCR_OFS_FUNC, `SUCR_OFS_IRQEN, `SUCR_OFS_BAUD, `SUCR_OFS_DATIN,
            `SUCR_OFS_CTLIN, `SUCR_OFS_CLKIN, `SUCR_OFS_LINE, `SUCR_OFS_TXW,
            `SUCR_OFS_RXW, `SUCR_OFS_BUFC, `SUCR_OFS_BUFS, `SUCR_OFS_DMAC,
            `SUCR_OFS_WKC, `SUCR_OFS_WKS, `SUCR_OFS_PROT, `SUCR_OFS_PIEN,
            `SUCR_OFS_PSTS, `SUCR_OFS_EVT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   wire [31:0] mode_merged = merge({29'h0, protocol_select_r}, avs_writedata, wmask);
   wire [31:0] wr_word = merge(rd_nxt, avs_writedata, wmask);
   wire [31:0] txw_merged = merge({16'h0, txw_r}, avs_writedata, wmask);
   wire [4:1] flag_clr = (wr_go && avs_address == `SUCR_OFS_PSTS && avs_byteenable[0]) ?
      avs_writedata[4:1] : 4'h0;
   wire mode_wr = wr_go && avs_address == `SUCR_OFS_FUNC;
   wire unit_on = (protocol_select_r != `SUCR_MODE_OFF);

   // ----------------------------------------
   // Clock chain as enables
   // ----------------------------------------
   // Reference is the bus clock; setting 1 is reserved and ignored
   wire ref_en = 1'b1;
   wire half_en = ref_half_r[0];
   wire prot_en = baud_r[`SUCR_PCS_BIT] ? half_en : ref_en;
   wire div_en;
   wire pre_en;
   wire den_en;
   reg samp_en;

   always @* begin
      case (baud_r[`SUCR_SCS_HI:`SUCR_SCS_LO])
         2'h0: samp_en = div_en;
         2'h1: samp_en = prot_en;
         2'h2: samp_en = sclk_en;
         2'h3: samp_en = ref_en;
         default: samp_en = 1'b0;
      endcase
   end

   sucr_divider #(.W(DIV_W)) u_div (
      .clock(clock), .rst_n(rst_n), .clear(~unit_on), .en_in(prot_en),
      .ratio(baud_r[`SUCR_DIV_HI:`SUCR_DIV_LO]), .en_out(div_en));
   sucr_divider #(.W(2)) u_pre (
      .clock(clock), .rst_n(rst_n), .clear(~unit_on), .en_in(samp_en),
      .ratio(baud_r[`SUCR_PRE_HI:`SUCR_PRE_LO]), .en_out(pre_en));
   sucr_divider #(.W(5)) u_den (
      .clock(clock), .rst_n(rst_n), .clear(~unit_on), .en_in(pre_en),
      .ratio(baud_r[`SUCR_DEN_HI:`SUCR_DEN_LO]), .en_out(den_en));

   wire meas_tick = baud_r[`SUCR_MSRC_BIT] ? div_en : prot_en;

   // ----------------------------------------
   // Input conditioning
   // ----------------------------------------
   wire d_raw = data_in ^ datin_r[`SUCR_INV_BIT];
   wire c_raw = ctrl_in ^ ctlin_r[`SUCR_INV_BIT];
   wire d_cond = datin_r[`SUCR_SYNC_BIT] ? d_sync_r[1] : d_raw;
   wire c_cond = ctlin_r[`SUCR_SYNC_BIT] ? c_sync_r[1] : c_raw;
   wire d_rise = d_sync_r[1] & ~d_prev_r;
   wire d_fall = ~d_sync_r[1] & d_prev_r;
   reg edge_hit;

   always @* begin
      case (datin_r[`SUCR_EDGE_HI:`SUCR_EDGE_LO])
         2'h0: edge_hit = 1'b0;
         2'h1: edge_hit = d_rise;
         2'h2: edge_hit = d_fall;
         2'h3: edge_hit = d_rise | d_fall;
         default: edge_hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always @* begin
      rd_nxt = 32'h0;
      case (avs_address)
         `SUCR_OFS_FUNC: rd_nxt = {29'h0, protocol_select_r};
         `SUCR_OFS_IRQEN: rd_nxt = {27'h0, irq_en_r, 1'b0};
         `SUCR_OFS_BAUD: rd_nxt = baud_r;
         `SUCR_OFS_DATIN: rd_nxt = {27'h0, datin_r[4:2], 1'b0, datin_r[0]};
         `SUCR_OFS_CTLIN: rd_nxt = {29'h0, ctlin_r[2], 1'b0, ctlin_r[0]};
         `SUCR_OFS_CLKIN: rd_nxt = {31'h0, clkin_r};
         `SUCR_OFS_LINE: rd_nxt = {20'h0, line_r};
         `SUCR_OFS_RXW: rd_nxt = {16'h0, rxw_r};
         `SUCR_OFS_BUFS: rd_nxt = `SUCR_RST_BUFS;
         `SUCR_OFS_DMAC: rd_nxt = {28'h0, dmac_r};
         `SUCR_OFS_WKC: rd_nxt = {31'h0, wkc_r};
         `SUCR_OFS_PROT: rd_nxt = prot_r;
         `SUCR_OFS_PSTS: rd_nxt = {27'h0, flags_r, 1'b0};
         `SUCR_OFS_EVT: rd_nxt = {22'h0, meas_r};
         default: rd_nxt = 32'h0;
      endcase
   end

   // ----------------------------------------
   // Bus slave and registers
   // ----------------------------------------
   // One wait cycle: waitrequest idles high, drops for one cycle on the edge that takes a request
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         avs_response <= 2'h0;
         rd_pend_r <= 1'b0;
         protocol_select_r <= 3'h0;
         irq_en_r <= 4'h0;
         baud_r <= `SUCR_RST_BAUD;
         datin_r <= 5'h0;
         ctlin_r <= 3'h0;
         clkin_r <= 1'b0;
         line_r <= 12'h0;
         txw_r <= 16'h0;
         prot_r <= 32'h0;
         dmac_r <= 4'h0;
         wkc_r <= 1'b0;
         flags_r <= 4'h0;
         rxw_r <= 16'h0;
      end else begin
         rd_pend_r <= 1'b0;
         avs_waitrequest <= ~(wr_go | rd_go);
         if (wr_go | rd_go) begin
            avs_response <= is_mapped(avs_address) ? 2'h0 : 2'h2;
            if (rd_go)
               avs_readdata <= rd_nxt;
         end
         if (wr_go) begin
            case (avs_address)
               `SUCR_OFS_FUNC: protocol_select_r <= mode_valid(mode_merged[2:0]) ?
                  mode_merged[2:0] : `SUCR_MODE_OFF;
               `SUCR_OFS_IRQEN: irq_en_r <= wr_word[4:1];
               `SUCR_OFS_BAUD: baud_r <= wr_word & 32'h03FF_7F3F;
               `SUCR_OFS_DATIN: datin_r <= wr_word[4:0] & 5'h1D;
               `SUCR_OFS_CTLIN: ctlin_r <= wr_word[2:0] & 3'h5;
               `SUCR_OFS_CLKIN: clkin_r <= avs_byteenable[0] ? avs_writedata[0] : clkin_r;
               `SUCR_OFS_LINE: line_r <= wr_word[11:0];
               `SUCR_OFS_TXW: txw_r <= txw_merged[15:0];
               `SUCR_OFS_DMAC: dmac_r <= wr_word[3:0];
               `SUCR_OFS_WKC: wkc_r <= avs_byteenable[0] ? avs_writedata[0] : wkc_r;
               `SUCR_OFS_PROT: prot_r <= wr_word;
               default: ;
            endcase
         end
         // Auto baud overwrite of divider field: a quarter of four bit times
         if (abr_arm_r && d_fall && abr_edges_r == `SUCR_ABRAUTO_CNT - 3'h1)
            baud_r[`SUCR_DIV_HI:`SUCR_DIV_LO] <= {2'h0, abr_cnt_r[9:2]};
         // Event flags: set wins over write-one clear
         if (!unit_on)
            flags_r <= 4'h0;
         else
            flags_r <= (flags_r & ~flag_clr) |
               {rx_done_evt, rx_begin_evt, tx_done_evt, tx_begin_evt};
         if (rx_done_evt)
            rxw_r <= rx_word;
      end
   end

   // ----------------------------------------
   // Clock chain state, measure counter, auto baud
   // ----------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ref_half_r <= 2'h0;
         meas_r <= 10'h0;
         // Line idles high, so no false edge after reset
         d_sync_r <= 2'h3;
         c_sync_r <= 2'h0;
         d_prev_r <= 1'b1;
         abr_edges_r <= 3'h0;
         abr_cnt_r <= 10'h0;
         abr_arm_r <= 1'b0;
      end else begin
         ref_half_r <= {ref_half_r[0], ~ref_half_r[0]};
         d_sync_r <= {d_sync_r[0], d_raw};
         c_sync_r <= {c_sync_r[0], c_raw};
         d_prev_r <= d_sync_r[1];
         if (!unit_on)
            meas_r <= 10'h0;
         else if (baud_r[`SUCR_MEN_BIT] && meas_tick)
            meas_r <= meas_r + 10'h1;
         // Measure four bit times between 2nd and 4th falling edges
         if (!unit_on || !prot_r[`SUCR_ABR_BIT]) begin
            abr_edges_r <= 3'h0;
            abr_arm_r <= 1'b0;
            abr_cnt_r <= 10'h0;
         end else if (d_fall) begin
            abr_arm_r <= 1'b1;
            abr_edges_r <= (abr_edges_r == `SUCR_ABRAUTO_CNT - 3'h1) ? 3'h0 :
               abr_edges_r + 3'h1;
            // Edge cycles count too, else each edge loses a tick
            if (abr_edges_r == 3'h1)
               abr_cnt_r <= {9'h0, prot_en};
            else if (prot_en && abr_edges_r >= 3'h2)
               abr_cnt_r <= abr_cnt_r + 10'h1;
         end else if (prot_en && abr_edges_r >= 3'h2) begin
            abr_cnt_r <= abr_cnt_r + 10'h1;
         end
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         protocol_active <= 1'b0;
         protocol_select_o <= 3'h0;
         unit_reset <= 1'b1;
         data_shift_in <= 1'b0;
         ctrl_shift_in <= 1'b0;
         data_edge_evt <= 1'b0;
         div_clk_en <= 1'b0;
         sample_cnt_en <= 1'b0;
         measure_count <= 10'h0;
         irq <= 1'b0;
      end else begin
         protocol_active <= unit_on;
         protocol_select_o <= protocol_select_r;
         unit_reset <= ~unit_on | (mode_wr && mode_merged[2:0] == 3'h0);
         data_shift_in <= d_cond;
         ctrl_shift_in <= c_cond;
         data_edge_evt <= edge_hit & unit_on;
         div_clk_en <= div_en;
         sample_cnt_en <= den_en;
         measure_count <= meas_r;
         irq <= |(flags_r & irq_en_r);
      end
   end

   // Keep unused latches of buffered-only fields visible to synthesis
   wire unused_ok = &{1'b0, txw_r[0], clkin_r, MY_BASE[0]};

endmodule // sucr_config_regs

`default_nettype wire

// ===== tb/sucr_line_model.sv
`default_nettype none
// ---------------------------------------
// Remote line transmitter
// ---------------------------------------
module sucr_line_model #(
   parameter int BIT_CYC = 8
) (
   // System
   input wire logic clock,
   // Control
   input wire logic send,
   input wire logic [7:0] byte_val,
   // Line
   output logic line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] frame;
   logic busy = 1'b0;
   logic line_r = 1'b1;
   assign line = line_r;
   // Idle high; start low, LSB first, one stop bit
   always @(posedge clock) begin
      if (send && !busy) begin
         busy <= 1'b1;
         frame = {1'b1, byte_val, 1'b0};
         for (int i = 0; i < 10; i++) begin
            line_r <= frame[i];
            repeat (BIT_CYC) @(posedge clock);
         end
         busy <= 1'b0;
      end
   end
endmodule // sucr_line_model
`default_nettype wire

// ===== tb/sucr_config_regs_props.sv
`default_nettype none
module sucr_chk (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   // Events and outputs
   input wire logic tx_begin_evt,
   input wire logic tx_done_evt,
   input wire logic rx_begin_evt,
   input wire logic rx_done_evt,
   input wire logic protocol_active,
   input wire logic [2:0] protocol_select_o,
   input wire logic unit_reset,
   input wire logic data_edge_evt,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [4:1] en_r;
   wire [4:1] evt = {rx_done_evt, rx_begin_evt, tx_done_evt, tx_begin_evt};
   wire [2:0] wm = avs_writedata[2:0];
   logic is_map;
   always @* begin
      case (avs_address)
         8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38,
         8'h3C, 8'h40, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h68: is_map = 1'b1;
         default: is_map = 1'b0;
      endcase
   end
   // Shadow of the enables, so event-to-irq can be judged
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         en_r <= 4'h0;
      end else if (avs_write && avs_waitrequest && avs_address == 8'h04 && avs_byteenable[0]) begin
         en_r <= avs_writedata[4:1];
      end
   end
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_bad_mode;
      avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0]
         && wm != 3'h1 && wm != 3'h2 && wm != 3'h4;
   endsequence
   a_wait_one: assert property (s_taken |=> !avs_waitrequest)
      else $error("waitrequest not low one cycle after request");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_unmap_resp: assert property (s_taken ##0 !is_map |=> avs_response == 2'h2)
      else $error("unmapped offset not answered with error");
   a_unmap_zero: assert property (s_taken ##0 (avs_read && !is_map) |=> avs_readdata == 32'h0)
      else $error("unmapped read data not zero");
   a_mode_reserved: assert property (s_bad_mode |-> ##[1:2] protocol_select_o == 3'h0)
      else $error("reserved mode code not disabling");
   a_mode_reset: assert property (protocol_select_o == 3'h0 && $stable(protocol_select_o) |-> unit_reset)
      else $error("unit not held in reset while disabled");
   a_mode_active: assert property ($stable(protocol_select_o) |-> protocol_active == (protocol_select_o != 3'h0))
      else $error("active flag disagrees with mode");
   a_evt_irq: assert property (|(evt & en_r) |-> ##2 irq)
      else $error("enabled event gave no interrupt");
   a_edge_gate: assert property (data_edge_evt |-> protocol_active)
      else $error("edge event while unit disabled");
endmodule // sucr_chk
bind sucr_config_regs sucr_chk u_chk (.clock, .rst_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
   .tx_begin_evt, .tx_done_evt, .rx_begin_evt, .rx_done_evt, .protocol_active,
   .protocol_select_o, .unit_reset, .data_edge_evt, .irq);
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic flip = 1'b0;
   logic ctrl_in = 1'b0;
   logic [4:1] evt = 4'h0;
   logic send = 1'b0;
   logic line, protocol_active, unit_reset, data_shift_in, ctrl_shift_in;
   logic data_edge_evt, div_clk_en, sample_cnt_en, irq;
   logic [2:0] psel;
   logic [9:0] measure_count;
   logic [31:0] q;
   logic [1:0] r;
   int errors = 0;
   int n_tests = 0;
   int c_div = 0;
   int c_smp = 0;
   int c_edge = 0;
   always #20 clock = ~clock;
   // Counted at the falling edge, away from the bench's own sampling
   always @(negedge clock) begin
      c_div += div_clk_en;
      c_smp += sample_cnt_en;
      c_edge += data_edge_evt;
   end
   sucr_config_regs dut (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_response,
      .data_in(line ^ flip), .ctrl_in, .sclk_en(1'b0), .tx_begin_evt(evt[1]),
      .tx_done_evt(evt[2]), .rx_begin_evt(evt[3]), .rx_done_evt(evt[4]),
      .rx_word(16'hA5C3), .protocol_active, .protocol_select_o(psel), .unit_reset,
      .data_shift_in, .ctrl_shift_in, .data_edge_evt, .div_clk_en, .sample_cnt_en,
      .measure_count, .irq);
   sucr_line_model #(.BIT_CYC(8)) u_line (.clock, .send, .byte_val(8'h55), .line);
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clock);
         n++;
         if (n > 50) begin
            errors++;
            report_and_stop();
         end
      end
      q = avs_readdata;
      r = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic t_reset();
      logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h3C, 8'h30, 8'h0C};
      logic [31:0] e[6] = '{32'h0, 32'h0, 32'h3C00, 32'h101, 32'h0, 32'h0};
      for (int i = 0; i < 6; i++) begin
         bus(0, a[i], 0);
         chk("reset value", e[i], q);
         chk("response", (i == 5) ? 2'h2 : 2'h0, r);
      end
      chk("unit reset", 1, unit_reset);
   endtask
   task automatic t_mode();
      logic [2:0] e;
      for (int m = 0; m < 8; m++) begin
         e = (m == 1 || m == 2 || m == 4) ? 3'(m) : 3'h0;
         bus(1, 8'h00, 0);
         bus(1, 8'h00, m);
         bus(0, 8'h00, 0);
         chk("mode", e, q);
         chk("mode out", e, psel);
         chk("active", e != 0, protocol_active);
         chk("unit reset", e == 0, unit_reset);
      end
   endtask
   task automatic t_irq();
      bus(1, 8'h00, 2);
      for (int i = 1; i < 5; i++) begin
         bus(1, 8'h04, 1 << i);
         for (int j = 1; j < 5; j++) begin
            evt[j] <= 1'b1;
            @(posedge clock);
            evt <= 4'h0;
            repeat (3) @(posedge clock);
            chk("irq", i == j, irq);
            bus(0, 8'h64, 0);
            chk("flags", 1 << j, q);
            bus(1, 8'h64, 1 << j);
            repeat (2) @(posedge clock);
            chk("irq clear", 0, irq);
         end
      end
      // Event lands on the very edge that takes the clear
      fork
         bus(1, 8'h64, 32'h2);
         begin
            evt[1] <= 1'b1;
            @(posedge clock);
            evt <= 4'h0;
         end
      join
      bus(0, 8'h64, 0);
      chk("set wins", 32'h2, q);
      bus(1, 8'h64, 32'h2);
      bus(0, 8'h34, 0);
      chk("rx word", 32'hA5C3, q);
   endtask
   task automatic t_clock();
      int d, s;
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 3; k++) begin
            bus(1, 8'h08, 32'h0003_1100 | ((k == 2 ? 3 : k) << 2) | (p << 1));
            repeat (100) @(posedge clock);
            d = c_div;
            s = c_smp;
            repeat (400) @(posedge clock);
            chk("div pulses", 100 / (p + 1), c_div - d);
            chk("smp pulses", k == 0 ? 10 / (p + 1) : k == 1 ? 40 / (p + 1) : 40, c_smp - s);
         end
      end
   endtask
   task automatic t_measure();
      logic [9:0] m0;
      for (int k = 0; k < 3; k++) begin
         bus(1, 8'h08, 32'h0003_1100 | (k < 2 ? 32'h10 : 32'h0) | (k == 1 ? 32'h20 : 32'h0));
         repeat (10) @(posedge clock);
         m0 = measure_count;
         repeat (100) @(posedge clock);
         chk("measure", k == 0 ? 100 : k == 1 ? 25 : 0, 10'(measure_count - m0));
      end
   endtask
   task automatic t_input();
      logic v;
      for (int k = 0; k < 4; k++) begin
         bus(1, 8'h10, (k[1] << 2) | k[0]);
         bus(1, 8'h20, (k[1] << 2) | k[0]);
         flip <= 1'b0;
         ctrl_in <= 1'b1;
         repeat (6) @(posedge clock);
         for (int b = 0; b < 2; b++) begin
            v = b[0];
            flip <= !v;
            ctrl_in <= v;
            repeat (2) @(posedge clock);
            // Synchronised path must still show the old level here
            chk("data early", (k[0] ? !v : v) ^ k[1], data_shift_in);
            chk("ctrl early", (k[0] ? !v : v) ^ k[1], ctrl_shift_in);
            repeat (4) @(posedge clock);
            chk("data", v ^ k[1], data_shift_in);
            chk("ctrl", v ^ k[1], ctrl_shift_in);
         end
      end
   endtask
   task automatic t_edge();
      int e0;
      int ex[4] = '{0, 5, 5, 10};
      for (int k = 0; k < 4; k++) begin
         bus(1, 8'h10, k << 3);
         repeat (5) @(posedge clock);
         e0 = c_edge;
         send <= 1'b1;
         @(posedge clock);
         send <= 1'b0;
         repeat (100) @(posedge clock);
         chk("edge events", ex[k], c_edge - e0);
      end
   endtask
   task automatic t_autobaud();
      bus(1, 8'h5C, 32'h40);
      bus(1, 8'h08, 32'h0003_1100);
      send <= 1'b1;
      @(posedge clock);
      send <= 1'b0;
      repeat (100) @(posedge clock);
      bus(0, 8'h08, 0);
      // Eight protocol ticks per bit on the line
      chk("auto baud", 32'h0008_1100, q);
      bus(1, 8'h5C, 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_reset();
      $display("reset test done");
      t_mode();
      $display("mode test done");
      t_irq();
      $display("irq test done");
      t_clock();
      $display("clock test done");
      t_measure();
      $display("measure test done");
      t_input();
      $display("input test done");
      t_edge();
      $display("edge test done");
      t_autobaud();
      $display("auto baud test done");
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
